/* File: verilog/smf_pkg.sv */
// Behaviour
// R1 - Key exchange response opens with zero 32-bit connection id, then 6-bit key index.
// R2 - Response flags byte: cookie sequence bit at bit 1, counter sequence at bit 0.
// R3 - Then clone counter byte, nonce of negotiated length, authenticator of hash length.
// R4 - Counter bump request: clone counter plus one modulo 256, counter sequence inverted.
// R5 - Centre resends key exchange with old cookie when cookie sequence shows mismatch.
// R6 - Centre treats a clone counter mismatch as a cloned terminal.
// R7 - Wait message: zero 32-bit connection id, echoed message type, zero reserved byte.
// R8 - Terminal sends a wait message while its reply is not ready yet.
// R9 - Centre restarts reply time-out and retry count on receiving a wait.
// R10 - Security-capable terminal filters and accepts the dedicated forward-path identifier.
// R11 - Messages travel as descriptors in UDP payloads, several back to back.
// R12 - Terminal-to-centre payload starts with the terminal's own MAC address.
// R13 - Descriptor is type byte, length byte, then exactly length message bytes.
// R14 - Type 0x0d marks key exchange, type 0x35 marks sign-on.
// R15 - Request flag bit 1 asks counter bump, bit 0 selects session key.
// R16 - Counter and sequence changes stay pending until connect confirmation commits them.
// R17 - Parser skips unknown types by length, discards descriptors overrunning the payload.
package smf_pkg;
	// Register byte offsets
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_STATUS = 12'h004;
	localparam logic [11:0] OFF_MAC_LO = 12'h008;
	localparam logic [11:0] OFF_MAC_HI = 12'h00c;
	localparam logic [11:0] OFF_LENS = 12'h010;
	localparam logic [11:0] OFF_COOKIE = 12'h014;
	localparam logic [11:0] OFF_WAIT_TYPE = 12'h018;
	localparam logic [11:0] OFF_PID = 12'h01c;
	localparam logic [11:0] OFF_DISCARDS = 12'h020;
	localparam logic [11:0] OFF_COMMITTED = 12'h024;
	localparam logic [3:0] BUF_PAGE = 4'h1;
	// Control bits
	localparam int CTRL_SEND = 0;
	localparam int CTRL_COMMIT = 1;
	localparam int CTRL_PID_EN = 2;
	localparam int CTRL_AUTO_WAIT = 3;
	// Request flag bits
	localparam int FLAG_BUMP = 1;
	localparam int FLAG_KEY_SEL = 0;
	// Descriptor types
	localparam logic [7:0] TLV_KEX = 8'h0d;
	localparam logic [7:0] TLV_SIGN_ON = 8'h35;
	localparam logic [7:0] TLV_WAIT = 8'h0d;
	// Message layout
	localparam logic [8:0] MAC_BYTES = 9'h006;
	localparam logic [8:0] HDR_END = 9'h008;
	localparam logic [8:0] CONN_ID_BYTES = 9'h004;
	localparam logic [7:0] RESP_FIXED = 8'h07;
	localparam logic [7:0] WAIT_LEN = 8'h06;
	localparam logic [7:0] REQ_MIN_LEN = 8'h06;
	localparam logic [7:0] REQ_KEY_POS = 8'h04;
	localparam logic [7:0] REQ_FLAG_POS = 8'h05;
	// Reset values
	localparam logic [7:0] COUNTER_RST = 8'h00;
	localparam logic [12:0] PID_RST = 13'h0000;
	localparam logic [7:0] WAIT_TYPE_RST = 8'h00;

	typedef struct packed {
		logic [5:0] key_idx;
		logic bump;
		logic key_sel;
	} smf_kex_req_t;

	typedef struct packed {
		logic is_wait;
		logic [47:0] mac;
		logic [5:0] key_idx;
		logic cookie_seq;
		logic counter_seq;
		logic [7:0] counter;
		logic [7:0] nonce_len;
		logic [7:0] hash_len;
		logic [7:0] wait_type;
	} smf_tx_req_t;
endpackage : smf_pkg

/* File: verilog/smf_rx_parser.sv */
`timescale 1ns/1ns
module smf_rx_parser (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Incoming UDP payload bytes
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_last,
	// Parsed results
	output smf_pkg::smf_kex_req_t kex_req,
	output logic kex_valid,
	output logic discard
);
	typedef enum logic [1:0] {SMF_TYPE, SMF_LEN, SMF_BODY} smf_rx_state_t;
	smf_rx_state_t state_r;
	logic [7:0] type_r;
	logic [7:0] len_r;
	logic [7:0] pos_r;
	smf_pkg::smf_kex_req_t req_r;

	wire is_kex = type_r == smf_pkg::TLV_KEX;
	wire body_end = pos_r == len_r - 8'h01;
	wire kex_ok = is_kex && len_r >= smf_pkg::REQ_MIN_LEN;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_r <= SMF_TYPE;
			type_r <= 8'h00;
			len_r <= 8'h00;
			pos_r <= 8'h00;
			req_r <= '0;
			kex_valid <= 1'b0;
			discard <= 1'b0;
		end else begin
			kex_valid <= 1'b0;
			discard <= 1'b0;
			if (rx_valid) begin
				case (state_r)
					SMF_TYPE: begin
						type_r <= rx_data;
						// R17 truncated header
						if (rx_last) begin
							discard <= 1'b1;
						end else begin
							state_r <= SMF_LEN;
						end
					end
					SMF_LEN: begin
						// R13 length then body
						len_r <= rx_data;
						pos_r <= 8'h00;
						if (rx_data == 8'h00) begin
							state_r <= SMF_TYPE;
						end else if (rx_last) begin
							discard <= 1'b1;
							state_r <= SMF_TYPE;
						end else begin
							state_r <= SMF_BODY;
						end
					end
					SMF_BODY: begin
						pos_r <= pos_r + 8'h01;
						// R15 request key index and flags
						if (pos_r == smf_pkg::REQ_KEY_POS) begin
							req_r.key_idx <= rx_data[5:0];
						end
						if (pos_r == smf_pkg::REQ_FLAG_POS) begin
							req_r.bump <= rx_data[smf_pkg::FLAG_BUMP];
							req_r.key_sel <= rx_data[smf_pkg::FLAG_KEY_SEL];
						end
						// R14 only key exchange is acted on
						if (body_end) begin
							kex_valid <= kex_ok;
							// R11 next descriptor may follow
							state_r <= SMF_TYPE;
						end else if (rx_last) begin
							// R17 overrun discards
							discard <= 1'b1;
							state_r <= SMF_TYPE;
						end
					end
					default: state_r <= SMF_TYPE;
				endcase
			end
		end
	end

	assign kex_req = req_r;
endmodule : smf_rx_parser

/* File: verilog/smf_tx_builder.sv */
`timescale 1ns/1ns
module smf_tx_builder #(
	parameter int AW = 6
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Start of one datagram
	input wire logic start,
	input smf_pkg::smf_tx_req_t req,
	output logic busy,
	// Nonce and authenticator store
	output logic [AW-1:0] buf_addr,
	input wire logic [7:0] buf_byte,
	// Outgoing UDP payload bytes
	output logic tx_valid,
	output logic [7:0] tx_data,
	output logic tx_last,
	input wire logic tx_ready
);
	smf_pkg::smf_tx_req_t req_r;
	logic [8:0] pos_r;

	wire [7:0] resp_len = smf_pkg::RESP_FIXED + req_r.nonce_len
		+ req_r.hash_len;
	wire [7:0] msg_len = req_r.is_wait ? smf_pkg::WAIT_LEN : resp_len;
	wire [8:0] total = smf_pkg::HDR_END + {1'b0, msg_len};
	wire [8:0] k = pos_r - smf_pkg::HDR_END;
	wire [8:0] buf_idx = k - {1'b0, smf_pkg::RESP_FIXED};
	wire [5:0] shift = 6'd40 - {pos_r[2:0], 3'b000};
	wire [47:0] mac_sh = req_r.mac >> shift;
	wire [7:0] type_byte = req_r.is_wait ? smf_pkg::TLV_WAIT
		: smf_pkg::TLV_KEX;
	// R1 R7 second field
	wire [7:0] b4 = req_r.is_wait ? req_r.wait_type
		: {2'b00, req_r.key_idx};
	// R2 flags, R7 reserved zero
	wire [7:0] b5 = req_r.is_wait ? 8'h00
		: {6'b000000, req_r.cookie_seq, req_r.counter_seq};
	wire [7:0] msg_byte = (k < smf_pkg::CONN_ID_BYTES) ? 8'h00
		: (k == 9'h004) ? b4 : (k == 9'h005) ? b5
		: (k == 9'h006) ? req_r.counter : buf_byte;
	// R12 MAC first, R13 type and length
	wire [7:0] next_byte = (pos_r < smf_pkg::MAC_BYTES) ? mac_sh[7:0]
		: (pos_r == 9'h006) ? type_byte
		: (pos_r == 9'h007) ? msg_len : msg_byte;
	wire advance = busy && (!tx_valid || tx_ready);

	// R3 nonce then authenticator from the store
	assign buf_addr = buf_idx[AW-1:0];

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			req_r <= '0;
			pos_r <= 9'h000;
			busy <= 1'b0;
			tx_valid <= 1'b0;
			tx_data <= 8'h00;
			tx_last <= 1'b0;
		end else begin
			if (start && !busy) begin
				req_r <= req;
				pos_r <= 9'h000;
				busy <= 1'b1;
			end else if (advance) begin
				pos_r <= pos_r + 9'h001;
				busy <= pos_r != total - 9'h001;
			end
			if (advance) begin
				tx_valid <= 1'b1;
				tx_data <= next_byte;
				tx_last <= pos_r == total - 9'h001;
			end else if (tx_ready) begin
				tx_valid <= 1'b0;
				tx_last <= 1'b0;
			end
		end
	end
endmodule : smf_tx_builder

/* File: verilog/smf_framer.sv */
// Our own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module smf_framer #(
	parameter int BUF_DEPTH = 64
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Received UDP payload, same clock domain
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_last,
	// Transmitted UDP payload
	output logic tx_valid,
	output logic [7:0] tx_data,
	output logic tx_last,
	input wire logic tx_ready,
	// Forward-path identifier check, same clock domain
	input wire logic pid_valid,
	input wire logic [12:0] pid_value,
	output logic pid_accept
);
	localparam int AW = $clog2(BUF_DEPTH);
	localparam int WORDS = BUF_DEPTH / 4;

	// Bus address phase capture
	logic wr_pend_r;
	logic [11:0] wr_addr_r;
	wire ahb_go = hsel && htrans[1] && hready;

	// Software registers
	logic [31:0] mac_lo_r;
	logic [15:0] mac_hi_r;
	logic [7:0] nonce_len_r;
	logic [7:0] hash_len_r;
	logic [7:0] wait_type_r;
	logic [12:0] pid_r;
	logic pid_en_r;
	logic auto_wait_r;
	logic [15:0] discards_r;

	// Working and committed clone state
	logic cookie_seq_r;
	logic counter_seq_r;
	logic [7:0] counter_r;
	logic cookie_seq_c_r;
	logic counter_seq_c_r;
	logic [7:0] counter_c_r;

	// Pending request
	logic req_pending_r;
	logic wait_owed_r;
	smf_pkg::smf_kex_req_t last_req_r;

	logic [7:0] buf_mem [BUF_DEPTH];
	logic [AW-1:0] tx_buf_addr;
	logic tx_busy;
	smf_pkg::smf_kex_req_t kex_req;
	logic kex_valid;
	logic rx_discard;

	// Write decode, applied in the data phase
	wire wr_ctrl = wr_pend_r && wr_addr_r == smf_pkg::OFF_CTRL;
	wire wr_mac_lo = wr_pend_r && wr_addr_r == smf_pkg::OFF_MAC_LO;
	wire wr_mac_hi = wr_pend_r && wr_addr_r == smf_pkg::OFF_MAC_HI;
	wire wr_lens = wr_pend_r && wr_addr_r == smf_pkg::OFF_LENS;
	wire wr_cookie = wr_pend_r && wr_addr_r == smf_pkg::OFF_COOKIE;
	wire wr_wait = wr_pend_r && wr_addr_r == smf_pkg::OFF_WAIT_TYPE;
	wire wr_pid = wr_pend_r && wr_addr_r == smf_pkg::OFF_PID;
	wire wr_buf = wr_pend_r && wr_addr_r[11:8] == smf_pkg::BUF_PAGE
		&& wr_addr_r[7:2] < WORDS[5:0];

	wire send_go = wr_ctrl && hwdata[smf_pkg::CTRL_SEND] && !tx_busy;
	wire commit_go = wr_ctrl && hwdata[smf_pkg::CTRL_COMMIT];
	// R8 wait goes out only when no reply is being started
	wire wait_go = wait_owed_r && !tx_busy && !send_go;
	wire bump_go = kex_valid && kex_req.bump;

	// R4 working counter values
	wire [7:0] counter_nxt = bump_go ? counter_r + 8'h01 : counter_r;
	wire counter_seq_nxt = bump_go ? !counter_seq_r : counter_seq_r;

	smf_pkg::smf_tx_req_t tx_req;
	assign tx_req.is_wait = !send_go;
	assign tx_req.mac = {mac_hi_r, mac_lo_r};
	assign tx_req.key_idx = last_req_r.key_idx;
	assign tx_req.cookie_seq = cookie_seq_r;
	assign tx_req.counter_seq = counter_seq_r;
	assign tx_req.counter = counter_r;
	assign tx_req.nonce_len = nonce_len_r;
	assign tx_req.hash_len = hash_len_r;
	assign tx_req.wait_type = wait_type_r;

	// Read selection from the address phase
	wire [11:0] ra = haddr[11:0];
	wire [AW-1:0] rb = {haddr[AW-1:2], 2'b00};
	wire [31:0] rd_buf = {buf_mem[rb + 2'd3], buf_mem[rb + 2'd2],
		buf_mem[rb + 2'd1], buf_mem[rb]};
	wire [31:0] rd_ctrl = {28'h0000000, auto_wait_r, pid_en_r, 2'b00};
	wire [31:0] rd_status = {6'h00, last_req_r.key_sel, last_req_r.bump,
		2'b00, last_req_r.key_idx, counter_r, 4'h0, counter_seq_r,
		cookie_seq_r, tx_busy, req_pending_r};
	wire [31:0] rd_committed = {14'h0000, cookie_seq_c_r,
		counter_seq_c_r, 8'h00, counter_c_r};
	wire [31:0] rd_mux =
		(ra == smf_pkg::OFF_CTRL) ? rd_ctrl :
		(ra == smf_pkg::OFF_STATUS) ? rd_status :
		(ra == smf_pkg::OFF_MAC_LO) ? mac_lo_r :
		(ra == smf_pkg::OFF_MAC_HI) ? {16'h0000, mac_hi_r} :
		(ra == smf_pkg::OFF_LENS) ? {16'h0000, hash_len_r, nonce_len_r} :
		(ra == smf_pkg::OFF_COOKIE) ? {31'h00000000, cookie_seq_r} :
		(ra == smf_pkg::OFF_WAIT_TYPE) ? {24'h000000, wait_type_r} :
		(ra == smf_pkg::OFF_PID) ? {19'h00000, pid_r} :
		(ra == smf_pkg::OFF_DISCARDS) ? {16'h0000, discards_r} :
		(ra == smf_pkg::OFF_COMMITTED) ? rd_committed :
		(ra[11:8] == smf_pkg::BUF_PAGE && ra[7:2] < WORDS[5:0]) ? rd_buf :
		32'h00000000;

	smf_rx_parser u_rx (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.rx_valid(rx_valid),
		.rx_data(rx_data),
		.rx_last(rx_last),
		.kex_req(kex_req),
		.kex_valid(kex_valid),
		.discard(rx_discard)
	);

	smf_tx_builder #(.AW(AW)) u_tx (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.start(send_go || wait_go),
		.req(tx_req),
		.busy(tx_busy),
		.buf_addr(tx_buf_addr),
		.buf_byte(buf_mem[tx_buf_addr]),
		.tx_valid(tx_valid),
		.tx_data(tx_data),
		.tx_last(tx_last),
		.tx_ready(tx_ready)
	);

	// Zero-wait slave: read data is prepared at the address phase
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 12'h000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_pend_r <= ahb_go && hwrite;
			if (ahb_go) begin
				wr_addr_r <= haddr[11:0];
			end
		end
	end

	// Read data stands until the next read address phase
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			hrdata <= 32'h00000000;
		end else if (ahb_go && !hwrite) begin
			hrdata <= rd_mux;
		end
	end

	// Nonce and authenticator store, byte lane n is entry 4i+n
	generate
		for (genvar w = 0; w < BUF_DEPTH; w++) begin : g_buf
			always_ff @(posedge clk_sys) begin
				if (wr_buf && wr_addr_r[7:2] == 6'(w / 4)) begin
					buf_mem[w] <= hwdata[8*(w%4) +: 8];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			mac_lo_r <= 32'h00000000;
			mac_hi_r <= 16'h0000;
		end else begin
			if (wr_mac_lo) mac_lo_r <= hwdata;
			if (wr_mac_hi) mac_hi_r <= hwdata[15:0];
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			nonce_len_r <= 8'h00;
			hash_len_r <= 8'h00;
		end else if (wr_lens) begin
			nonce_len_r <= hwdata[7:0];
			hash_len_r <= hwdata[15:8];
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			wait_type_r <= smf_pkg::WAIT_TYPE_RST;
		end else if (wr_wait) begin
			wait_type_r <= hwdata[7:0];
		end
	end

	// R10 identifier to match
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pid_r <= smf_pkg::PID_RST;
		end else if (wr_pid) begin
			pid_r <= hwdata[12:0];
		end
	end

	// Every control write rewrites both mode bits
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pid_en_r <= 1'b0;
			auto_wait_r <= 1'b0;
		end else if (wr_ctrl) begin
			pid_en_r <= hwdata[smf_pkg::CTRL_PID_EN];
			auto_wait_r <= hwdata[smf_pkg::CTRL_AUTO_WAIT];
		end
	end

	// R4 bump and invert
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cookie_seq_r <= 1'b0;
			counter_seq_r <= 1'b0;
			counter_r <= smf_pkg::COUNTER_RST;
		end else begin
			counter_r <= counter_nxt;
			counter_seq_r <= counter_seq_nxt;
			if (wr_cookie) cookie_seq_r <= hwdata[0];
		end
	end

	// R16 commit on confirmation only
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cookie_seq_c_r <= 1'b0;
			counter_seq_c_r <= 1'b0;
			counter_c_r <= smf_pkg::COUNTER_RST;
		end else if (commit_go) begin
			cookie_seq_c_r <= cookie_seq_r;
			counter_seq_c_r <= counter_seq_r;
			counter_c_r <= counter_r;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			last_req_r <= '0;
		end else if (kex_valid) begin
			last_req_r <= kex_req;
		end
	end

	// New request wins over a same-cycle send
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			req_pending_r <= 1'b0;
		end else begin
			req_pending_r <= kex_valid || (req_pending_r && !send_go);
		end
	end

	// R8 owe a wait while the reply is pending
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			wait_owed_r <= 1'b0;
		end else begin
			wait_owed_r <= (kex_valid && auto_wait_r)
				|| (wait_owed_r && !wait_go && !send_go);
		end
	end

	// R17 count dropped descriptors, wraps silently
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			discards_r <= 16'h0000;
		end else if (rx_discard) begin
			discards_r <= discards_r + 16'h0001;
		end
	end

	// R10 identifier filter
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pid_accept <= 1'b0;
		end else begin
			pid_accept <= pid_en_r && pid_valid && pid_value == pid_r;
		end
	end
endmodule : smf_framer

/* File: dv/smf_framer_assertions.sv */
`timescale 1ns/1ns
module smf_framer_assertions (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Bus answer
	input logic hreadyout,
	input logic hresp,
	// Outgoing stream
	input logic tx_valid,
	input logic [7:0] tx_data,
	input logic tx_last,
	input wire logic tx_ready,
	// Identifier filter
	input wire logic pid_valid,
	input logic pid_accept
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	logic [8:0] cnt;
	logic [7:0] len_q;
	wire acc = tx_valid && tx_ready;
	wire is_wait = len_q == 8'h06;
	// Byte index inside the datagram, header is bytes 0 to 7
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cnt <= 9'h000;
			len_q <= 8'h00;
		end else if (acc) begin
			cnt <= tx_last ? 9'h000 : cnt + 9'h001;
			if (cnt == 9'h007) begin
				len_q <= tx_data;
			end
		end
	end
	sequence s_stall;
		tx_valid && !tx_ready;
	endsequence
	sequence s_held;
		tx_valid && $stable(tx_data) && $stable(tx_last);
	endsequence
	AST_HOLD: assert property (s_stall |=> s_held)
		else $error("byte changed while stalled");
	AST_TYPE: assert property (acc && cnt == 9'h006 |-> tx_data == 8'h0d)
		else $error("descriptor type wrong");
	AST_MINLEN: assert property (acc && cnt == 9'h007 |-> tx_data >= 8'h06)
		else $error("message too short");
	AST_CONN: assert property (acc && cnt >= 9'h008 && cnt <= 9'h00b
		|-> tx_data == 8'h00)
		else $error("connection id not zero");
	AST_LEN: assert property (acc && tx_last |-> cnt == len_q + 9'h007)
		else $error("length does not match bytes");
	AST_KEY: assert property (acc && cnt == 9'h00c && !is_wait
		|-> tx_data[7:6] == 2'b00)
		else $error("key index wider than six bits");
	AST_FLAGS: assert property (acc && cnt == 9'h00d && !is_wait
		|-> tx_data[7:2] == 6'h00)
		else $error("flag byte upper bits set");
	AST_RSVD: assert property (acc && cnt == 9'h00d && is_wait
		|-> tx_data == 8'h00)
		else $error("wait reserved byte not zero");
	AST_PID: assert property (pid_accept |-> $past(pid_valid))
		else $error("identifier accepted without request");
	AST_BUS: assert property (hreadyout && !hresp)
		else $error("bus not ready or not okay");
endmodule : smf_framer_assertions

/* File: dv/smf_ncc_model.sv */
`timescale 1ns/1ns
module smf_ncc_model (
	// Clock
	input wire logic clk_sys,
	// Centre to terminal
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_last,
	// Terminal to centre
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	output logic tx_ready
);
	typedef logic [7:0] smf_bytes_t[$];
	int seed = 32'h154c1dd2;
	bit slow = 1'b0;
	int frames = 0;
	int idx = 0;
	int retry = 0;
	logic [7:0] got[$];
	logic [7:0] exp_ctr = 8'h00;
	logic exp_cseq = 1'b0;
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_last = 1'b0;
		tx_ready = 1'b1;
	end
	// Random stalls only when asked; the test asks before its first frame, so every frame meets a slow sink
	always @(posedge clk_sys) begin
		tx_ready <= !slow || ($random(seed) & 1) == 0;
		if (tx_valid && tx_ready) begin
			got.push_back(tx_data);
			if (idx == 7 && tx_data == 8'h06) begin
				retry = 0;
			end
			idx <= tx_last ? 0 : idx + 1;
			frames <= frames + (tx_last ? 1 : 0);
		end
	end
	task send(input smf_bytes_t b);
		foreach (b[i]) begin
			@(posedge clk_sys);
			rx_valid <= 1'b1;
			rx_data <= b[i];
			rx_last <= i == b.size() - 1;
		end
		@(posedge clk_sys);
		rx_valid <= 1'b0;
		rx_last <= 1'b0;
		// Released line shows the inverse so a stale byte never looks valid
		rx_data <= ~b[b.size() - 1];
	endtask : send
	task request(input logic [5:0] key, input logic bump, input logic sel);
		retry++;
		exp_ctr = exp_ctr + {7'h00, bump};
		exp_cseq = exp_cseq ^ bump;
		send('{8'h0d, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00, {2'b00, key},
			{6'h00, bump, sel}});
	endtask : request
endmodule : smf_ncc_model

/* File: dv/tb_security_message_framer.sv */
`timescale 1ns/1ns
module tb_security_message_framer;
	logic clk_sys, rstn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd, r32, mac_lo, mac_hi;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic rx_valid, rx_last, tx_valid, tx_last, tx_ready;
	logic [7:0] rx_data, tx_data, n_len, h_len, wt;
	logic pid_valid, pid_accept, ck;
	logic [12:0] pid_value;
	logic [5:0] key;
	logic [7:0] ebuf[$];
	logic [7:0] bufb[64];
	int miscompares = 0;
	int checks = 0;
	int seed = 32'h154c1dd2;
	assign hready = hreadyout;
	smf_framer i_dut (.clk_sys(clk_sys), .rstn(rstn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_last(rx_last), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
		.pid_valid(pid_valid), .pid_value(pid_value),
		.pid_accept(pid_accept));
	smf_ncc_model i_ncc (.clk_sys(clk_sys), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_last(rx_last), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task finish_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : finish_test
	task wait_ready;
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (hready !== 1'b1 && n < 100);
		if (hready !== 1'b1) begin
			chk(32'h0, 32'h1);
			finish_test();
		end
	endtask : wait_ready
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {20'h00000, a};
		hwrite <= w;
		wait_ready();
		htrans <= 2'b00;
		hwdata <= d;
		wait_ready();
		rd = hrdata;
	endtask : bus
	task pid(input logic [12:0] v, input logic exp);
		pid_valid <= 1'b1;
		pid_value <= v;
		@(posedge clk_sys);
		pid_valid <= 1'b0;
		#1;
		chk({31'h0, pid_accept}, {31'h0, exp});
		@(posedge clk_sys);
	endtask : pid
	function automatic logic [31:0] st(logic s, logic b, logic [7:0] c,
		logic q);
		return {6'h00, s, b, 2'b00, key, c, 4'h0, q, ck, 2'b00};
	endfunction : st
	function void head(input logic [7:0] len);
		ebuf.delete();
		for (int i = 0; i < 6; i++) begin
			ebuf.push_back(i < 2 ? mac_hi[15 - 8 * i -: 8]
				: mac_lo[31 - 8 * (i - 2) -: 8]);
		end
		ebuf.push_back(8'h0d);
		ebuf.push_back(len);
		repeat (4) ebuf.push_back(8'h00);
	endfunction : head
	task frame(input int n);
		for (int k = 0; k < 4000 && i_ncc.frames < n; k++) begin
			@(posedge clk_sys);
		end
		chk(32'(i_ncc.got.size()), 32'(ebuf.size()));
		foreach (ebuf[i]) chk(i_ncc.got[i], ebuf[i]);
		i_ncc.got.delete();
		if (i_ncc.frames < n) begin
			chk(32'h0, 32'h1);
			finish_test();
		end
	endtask : frame
	task status;
		repeat (3) @(posedge clk_sys);
		bus(1'b0, smf_pkg::OFF_STATUS, 32'h0);
		rd = rd & 32'h033fff0c;
	endtask : status
	initial begin
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'b010;
		pid_valid = 1'b0;
		pid_value = 13'h0000;
		rstn = 1'b0;
		ck = 1'b0;
		key = 6'h00;
		repeat (8) @(posedge clk_sys);
		rstn <= 1'b1;
		bus(1'b0, smf_pkg::OFF_STATUS, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, 12'h080, 32'h0);
		chk(rd, 32'h0);
		$display("test reset done");
		r32 = $random(seed);
		bus(1'b1, smf_pkg::OFF_PID, r32);
		bus(1'b1, smf_pkg::OFF_CTRL, 32'h4);
		pid(r32[12:0], 1'b1);
		pid(r32[12:0] ^ 13'h0001, 1'b0);
		bus(1'b1, smf_pkg::OFF_CTRL, 32'h0);
		pid(r32[12:0], 1'b0);
		$display("test identifier filter done");
		mac_lo = $random(seed);
		mac_hi = $random(seed) & 32'hffff;
		bus(1'b1, smf_pkg::OFF_MAC_LO, mac_lo);
		bus(1'b1, smf_pkg::OFF_MAC_HI, mac_hi);
		for (int w = 0; w < 16; w++) begin
			r32 = $random(seed);
			bus(1'b1, 12'h100 + 12'(4 * w), r32);
			for (int k = 0; k < 4; k++) bufb[4 * w + k] = r32[8 * k +: 8];
		end
		r32 = $random(seed);
		n_len = {6'h00, r32[1:0]} + 8'h01;
		h_len = {6'h00, r32[3:2]} + 8'h01;
		ck = r32[4];
		key = r32[10:5];
		bus(1'b1, smf_pkg::OFF_LENS, {16'h0, h_len, n_len});
		bus(1'b1, smf_pkg::OFF_COOKIE, {31'h0, ck});
		i_ncc.request(key, 1'b1, 1'b1);
		status();
		chk(rd, st(1'b1, 1'b1, 8'h01, 1'b1));
		i_ncc.slow = 1'b1;
		bus(1'b1, smf_pkg::OFF_CTRL, 32'h1);
		head(8'h07 + n_len + h_len);
		ebuf.push_back({2'b00, key});
		ebuf.push_back({6'h00, ck, 1'b1});
		ebuf.push_back(8'h01);
		for (int i = 0; i < n_len + h_len; i++) ebuf.push_back(bufb[i]);
		frame(1);
		bus(1'b0, smf_pkg::OFF_COMMITTED, 32'h0);
		chk(rd, 32'h0);
		bus(1'b1, smf_pkg::OFF_CTRL, 32'h2);
		bus(1'b0, smf_pkg::OFF_COMMITTED, 32'h0);
		chk(rd, {14'h0, ck, 1'b1, 8'h00, 8'h01});
		$display("test response done");
		for (int i = 0; i < 256; i++) begin
			r32 = $random(seed);
			key = r32[5:0];
			i_ncc.request(key, i < 255, r32[6]);
		end
		status();
		chk(rd, st(r32[6], 1'b0, i_ncc.exp_ctr, i_ncc.exp_cseq));
		chk(rd[15:8], 8'h00);
		$display("test counter wrap done");
		wt = $random(seed);
		bus(1'b1, smf_pkg::OFF_WAIT_TYPE, {24'h0, wt});
		bus(1'b1, smf_pkg::OFF_CTRL, 32'h8);
		i_ncc.request(key, 1'b0, 1'b0);
		head(8'h06);
		ebuf.push_back(wt);
		ebuf.push_back(8'h00);
		frame(2);
		chk(32'(i_ncc.retry), 32'h0);
		bus(1'b1, smf_pkg::OFF_CTRL, 32'h0);
		$display("test wait done");
		key = ~key;
		i_ncc.send('{8'h35, 8'h00, 8'h35, 8'h02, 8'haa, 8'h55, 8'h0d, 8'h06,
			8'h00, 8'h00, 8'h00, 8'h00, {2'b00, key}, 8'h02});
		status();
		chk(rd, st(1'b0, 1'b1, 8'h01, 1'b1));
		i_ncc.send('{8'h0d, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h15});
		i_ncc.send('{8'h0d});
		i_ncc.send('{8'h35, 8'h02});
		status();
		chk(rd, st(1'b0, 1'b1, 8'h01, 1'b1));
		bus(1'b0, smf_pkg::OFF_DISCARDS, 32'h0);
		chk(rd, 32'h3);
		$display("test descriptor parsing done");
		finish_test();
	end
endmodule : tb_security_message_framer
bind smf_framer smf_framer_assertions i_chk (.clk_sys(clk_sys),
	.rstn(rstn), .hreadyout(hreadyout), .hresp(hresp),
	.tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
	.tx_ready(tx_ready), .pid_valid(pid_valid), .pid_accept(pid_accept));
